//--- rpqr_pkg.sv
// package of the reference priority and qualification register bank
// assumes a single 100 MHz core clock; all numbers used by the bank live here

package rpqr_pkg;

    // ****************************************************************
    // register offsets (7-bit register address of the serial port)
    // ****************************************************************
    localparam logic [6:0] ADDR_PRIO_REFS_1_2 = 7'h00;
    localparam logic [6:0] ADDR_PRIO_REFS_3_4 = 7'h01;
    localparam logic [6:0] ADDR_PRIO_REFS_5_6 = 7'h02;
    localparam logic [6:0] ADDR_REF1_FREQ_OFFSET = 7'h04;
    localparam logic [6:0] ADDR_FOLLOWER_FREQ_OFFSET = 7'h0A;
    localparam logic [6:0] ADDR_REF_STATUS_1_TO_4 = 7'h0C;
    localparam logic [6:0] ADDR_REF_STATUS_5_6_FOLLOWER = 7'h0D;
    localparam logic [6:0] ADDR_LOOP_STATE_AND_ACTIVE_REF = 7'h0E;
    localparam logic [6:0] ADDR_REJECT_LIMIT = 7'h10;
    localparam logic [6:0] ADDR_QUALIFY_LIMIT = 7'h11;

    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic [7:0] RST_PRIO_REFS_1_2 = 8'h56;
    localparam logic [7:0] RST_PRIO_REFS_3_4 = 8'h34;
    localparam logic [7:0] RST_PRIO_REFS_5_6 = 8'h12;
    localparam logic [7:0] RST_FREQ_OFFSET = 8'hFF;
    localparam logic [1:0] RST_REF_STATUS = 2'h0;
    localparam logic [3:0] RST_LOOP_STATE = 4'h9;
    localparam logic [2:0] RST_ACTIVE_REF = 3'h0;
    localparam logic [7:0] RST_REJECT_LIMIT = 8'h1F;
    localparam logic [7:0] RST_QUALIFY_LIMIT = 8'h19;

    // ****************************************************************
    // field positions and codes
    // ****************************************************************
    localparam int NUM_SEL_REFS = 6;
    localparam int NUM_MEAS_INPUTS = 7;
    localparam int FOLLOWER_IDX = 6;
    localparam int PRIO_W = 4;
    localparam logic [3:0] PRIO_NONE = 4'h0;
    localparam logic [3:0] PRIO_TOP = 4'h6;
    localparam logic [7:0] OFFSET_POS_MAX = 8'h7F;
    localparam logic [7:0] OFFSET_NEG_MAX = 8'h80;
    localparam logic [7:0] MAGNITUDE_MAX = 8'hFF;
    localparam logic [1:0] STAT_ABSENT = 2'h0;
    localparam logic [1:0] STAT_DISQUALIFIED = 2'h1;
    localparam logic [1:0] STAT_IGNORED = 2'h2;
    localparam logic [1:0] STAT_QUALIFIED = 2'h3;
    localparam logic [2:0] ACTIVE_REF_NONE = 3'h0;

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int CLK_FREQ_MHZ = 100;
    localparam int QUAL_TIME_S = 10;
    localparam int TICK_TIME_US = 1000;
    localparam int TICK_CYCLES = TICK_TIME_US * CLK_FREQ_MHZ;
    localparam int QUAL_TICKS = (QUAL_TIME_S * 1000000) / TICK_TIME_US;
    localparam int TICK_CNT_W = 17;
    localparam int QUAL_CNT_W = 14;

    // ****************************************************************
    // types
    // ****************************************************************
    typedef enum logic [0:0] {
        RPQR_PH_ADDR,
        RPQR_PH_DATA
    } rpqr_phase_e;

    typedef struct packed {
        logic [2:0] clk_sync;
        logic [1:0] mosi_sync;
        logic [1:0] sel_sync;
        rpqr_phase_e phase;
        logic [2:0] bit_cnt;
        logic rd;
        logic skip_fall;
        logic [6:0] addr;
        logic [7:0] shift;
        logic [7:0] tx;
        logic spi_out;
        logic spi_oe;
        logic [2:0][7:0] prio;
        logic [6:0][7:0] offset;
        logic [6:0][7:0] magnitude;
        logic [6:0][1:0] status;
        logic [6:0] qual;
        logic [6:0][QUAL_CNT_W-1:0] qual_cnt;
        logic [TICK_CNT_W-1:0] tick_cnt;
        logic tick;
        logic [7:0] reject;
        logic [7:0] qualify;
        logic hist;
        logic [2:0] active;
        logic [3:0] loop_state;
        logic [2:0] sel_ref;
        logic [5:0] avail;
    } rpqr_state_s;

endpackage

//--- rpqr_regs.sv
// register bank for reference priorities, offsets, qualification and loop status
// assumes: serial port pins arrive unsynchronised; measurement, presence and loop
// inputs come from logic on core_clk_i; host keeps its serial clock below 10 MHz
//
// Contract
// - three priority registers, two nibbles each
// - host overwrites priorities; 0 lowest, 6 highest
// - priority zero: measured, never available
// - equal priorities: lowest reference number wins
// - priority above six acts as six
// - signed half-ppm offsets at 04h..0Ah
// - offsets saturate at +63.5 / -64 ppm
// - offsets reset to all ones
// - reported offset within 1.5 ppm
// - two-bit statuses packed in 0Ch, 0Dh
// - status codes absent/disq/ignored/qualified
// - statuses and reserved bits reset zero
// - qualify after ten clean seconds; restart when absent or beyond reject limit
// - loop status 0Eh, reset 0/000/1001
// - history flag set, kept into holdover
// - history flag cleared on change/freerun/clear; here history valid beats a clear in the same cycle
// - build-out indication passes through loop status
// - writable reject 10h, qualify 11h limits
// - limits reset 1Fh and 19h
// - limits unsigned half-ppm, symmetric

`timescale 1ns/1ps

module rpqr_regs #(
    parameter int unsigned TICK_CYCLES = rpqr_pkg::TICK_CYCLES,
    parameter int unsigned QUAL_TICKS = rpqr_pkg::QUAL_TICKS
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    // serial register port pins
    input wire logic spi_clk_i,
    input wire logic spi_in_i,
    input wire logic spi_sel_n_i,
    output logic spi_out_o,
    output logic spi_out_oe_o,
    // frequency measurement and presence
    input wire logic meas_valid_i,
    input wire logic [2:0] meas_idx_i,
    input wire logic signed [15:0] meas_offset_i,
    input wire logic [6:0] ref_present_i,
    // loop status
    input wire logic [3:0] loop_state_i,
    input wire logic [2:0] active_ref_i,
    input wire logic history_valid_i,
    input wire logic free_run_i,
    input wire logic holdover_history_clear_i,
    input wire logic auto_revertive_i,
    // results
    output logic [2:0] sel_ref_o,
    output logic [5:0] ref_avail_o,
    output logic [6:0] ref_qualified_o,
    output logic holdover_history_available_o
);

    // ****************************************************************
    // parameter checks
    // ****************************************************************
    if (TICK_CYCLES < 2 || TICK_CYCLES > (1 << rpqr_pkg::TICK_CNT_W)) begin : g_tick_chk
        $error("tick period does not fit the tick counter");
    end
    if (QUAL_TICKS < 1 || QUAL_TICKS > (1 << rpqr_pkg::QUAL_CNT_W)) begin : g_qual_chk
        $error("qualification interval does not fit the interval counter");
    end

    localparam logic [rpqr_pkg::TICK_CNT_W-1:0] TICK_LAST = rpqr_pkg::TICK_CNT_W'(TICK_CYCLES - 1);
    localparam logic [rpqr_pkg::QUAL_CNT_W-1:0] QUAL_LAST = rpqr_pkg::QUAL_CNT_W'(QUAL_TICKS - 1);

    // ****************************************************************
    // functions
    // ****************************************************************
    function automatic logic [3:0] eff_prio(input logic [3:0] p);
        eff_prio = (p > rpqr_pkg::PRIO_TOP) ? rpqr_pkg::PRIO_TOP : p;
    endfunction

    function automatic logic [7:0] sat_offset(input logic signed [15:0] v);
        if (v > 16'sh007F) begin
            sat_offset = rpqr_pkg::OFFSET_POS_MAX;
        end else if (v < -16'sh0080) begin
            sat_offset = rpqr_pkg::OFFSET_NEG_MAX;
        end else begin
            sat_offset = v[7:0];
        end
    endfunction

    // magnitude for the symmetric limit check, clipped at 127.5 ppm
    function automatic logic [7:0] sat_magnitude(input logic signed [15:0] v);
        logic [15:0] m;
        m = v[15] ? 16'(-v) : 16'(v);
        sat_magnitude = (m > 16'h00FF) ? rpqr_pkg::MAGNITUDE_MAX : m[7:0];
    endfunction

    function automatic logic [7:0] read_reg(input rpqr_pkg::rpqr_state_s st, input logic [6:0] a);
        read_reg = 8'h00;
        case (a)
            rpqr_pkg::ADDR_PRIO_REFS_1_2: read_reg = st.prio[0];
            rpqr_pkg::ADDR_PRIO_REFS_3_4: read_reg = st.prio[1];
            rpqr_pkg::ADDR_PRIO_REFS_5_6: read_reg = st.prio[2];
            rpqr_pkg::ADDR_REF_STATUS_1_TO_4: read_reg = st.status[3:0];
            rpqr_pkg::ADDR_REF_STATUS_5_6_FOLLOWER: read_reg = {2'h0, st.status[6:4]};
            rpqr_pkg::ADDR_LOOP_STATE_AND_ACTIVE_REF: read_reg = {st.hist, st.active, st.loop_state};
            rpqr_pkg::ADDR_REJECT_LIMIT: read_reg = st.reject;
            rpqr_pkg::ADDR_QUALIFY_LIMIT: read_reg = st.qualify;
            default: begin
                // offsets 04h..0Ah; everything else unmapped reads zero
                if (a >= rpqr_pkg::ADDR_REF1_FREQ_OFFSET && a <= rpqr_pkg::ADDR_FOLLOWER_FREQ_OFFSET) begin
                    read_reg = st.offset[3'(a - rpqr_pkg::ADDR_REF1_FREQ_OFFSET)];
                end
            end
        endcase
    endfunction

    function automatic rpqr_pkg::rpqr_state_s reset_state();
        rpqr_pkg::rpqr_state_s st;
        st = '0;
        st.phase = rpqr_pkg::RPQR_PH_ADDR;
        // idle deselected level, so no spurious select right after reset
        st.sel_sync = 2'h3;
        st.prio[0] = rpqr_pkg::RST_PRIO_REFS_1_2;
        st.prio[1] = rpqr_pkg::RST_PRIO_REFS_3_4;
        st.prio[2] = rpqr_pkg::RST_PRIO_REFS_5_6;
        for (int i = 0; i < rpqr_pkg::NUM_MEAS_INPUTS; i++) begin
            st.offset[i] = rpqr_pkg::RST_FREQ_OFFSET;
            st.magnitude[i] = rpqr_pkg::MAGNITUDE_MAX;
            st.status[i] = rpqr_pkg::RST_REF_STATUS;
        end
        st.reject = rpqr_pkg::RST_REJECT_LIMIT;
        st.qualify = rpqr_pkg::RST_QUALIFY_LIMIT;
        st.loop_state = rpqr_pkg::RST_LOOP_STATE;
        st.active = rpqr_pkg::RST_ACTIVE_REF;
        reset_state = st;
    endfunction

    // ****************************************************************
    // state
    // ****************************************************************
    rpqr_pkg::rpqr_state_s s;
    rpqr_pkg::rpqr_state_s n;
    logic sclk_rise;
    logic sclk_fall;
    logic sel_active;
    logic [7:0] shifted;
    logic ref_change;
    logic [3:0] best_prio;
    logic [2:0] best_ref;
    logic [3:0] prio_eff;

    always_comb begin
        n = s;
        sclk_rise = s.clk_sync[1] & ~s.clk_sync[2];
        sclk_fall = ~s.clk_sync[1] & s.clk_sync[2];
        sel_active = ~s.sel_sync[1];
        shifted = {s.shift[6:0], s.mosi_sync[1]};
        ref_change = 1'b0;
        best_prio = rpqr_pkg::PRIO_NONE;
        best_ref = rpqr_pkg::ACTIVE_REF_NONE;
        prio_eff = rpqr_pkg::PRIO_NONE;

        // pin synchronisers; first stage feeds only the second
        n.clk_sync = {s.clk_sync[1:0], spi_clk_i};
        n.mosi_sync = {s.mosi_sync[0], spi_in_i};
        n.sel_sync = {s.sel_sync[0], spi_sel_n_i};

        // ************************************************************
        // serial port: address byte then data byte, MSB first
        // ************************************************************
        if (!sel_active) begin
            n.phase = rpqr_pkg::RPQR_PH_ADDR;
            n.bit_cnt = 3'h0;
            n.spi_oe = 1'b0;
            n.skip_fall = 1'b0;
        end else if (sclk_rise) begin
            n.shift = shifted;
            n.bit_cnt = s.bit_cnt + 3'h1;
            if (s.bit_cnt == 3'h7) begin
                case (s.phase)
                    rpqr_pkg::RPQR_PH_ADDR: begin
                        n.rd = shifted[7];
                        n.addr = shifted[6:0];
                        n.phase = rpqr_pkg::RPQR_PH_DATA;
                        if (shifted[7]) begin
                            // snapshot taken at address time, shifted out on falling edges
                            n.tx = read_reg(s, shifted[6:0]);
                            n.spi_out = n.tx[7];
                            n.spi_oe = 1'b1;
                            n.skip_fall = 1'b1;
                        end
                    end
                    rpqr_pkg::RPQR_PH_DATA: begin
                        n.phase = rpqr_pkg::RPQR_PH_ADDR;
                        n.spi_oe = 1'b0;
                        if (!s.rd) begin
                            // read-only and unmapped addresses ignore writes
                            case (s.addr)
                                rpqr_pkg::ADDR_PRIO_REFS_1_2: n.prio[0] = shifted;
                                rpqr_pkg::ADDR_PRIO_REFS_3_4: n.prio[1] = shifted;
                                rpqr_pkg::ADDR_PRIO_REFS_5_6: n.prio[2] = shifted;
                                rpqr_pkg::ADDR_REJECT_LIMIT: n.reject = shifted;
                                rpqr_pkg::ADDR_QUALIFY_LIMIT: n.qualify = shifted;
                                default: n.addr = s.addr;
                            endcase
                        end
                    end
                    default: n.phase = rpqr_pkg::RPQR_PH_ADDR;
                endcase
            end
        end else if (sclk_fall && s.phase == rpqr_pkg::RPQR_PH_DATA && s.rd) begin
            // the host samples bit 7 on the first data rise, so hold it over one fall
            if (s.skip_fall) begin
                n.skip_fall = 1'b0;
            end else begin
                n.tx = {s.tx[6:0], 1'b0};
                n.spi_out = s.tx[6];
            end
        end

        // ************************************************************
        // offset capture
        // ************************************************************
        if (meas_valid_i && meas_idx_i < 3'(rpqr_pkg::NUM_MEAS_INPUTS)) begin
            n.offset[meas_idx_i] = sat_offset(meas_offset_i);
            n.magnitude[meas_idx_i] = sat_magnitude(meas_offset_i);
        end

        // ************************************************************
        // qualification timing: one tick per millisecond
        // ************************************************************
        n.tick = 1'b0;
        if (s.tick_cnt == TICK_LAST) begin
            n.tick_cnt = '0;
            n.tick = 1'b1;
        end else begin
            n.tick_cnt = s.tick_cnt + 1'b1;
        end

        for (int i = 0; i < rpqr_pkg::NUM_MEAS_INPUTS; i++) begin
            if (!ref_present_i[i] || n.magnitude[i] > s.reject) begin
                n.qual[i] = 1'b0;
                n.qual_cnt[i] = '0;
            end else if (n.magnitude[i] <= s.qualify) begin
                if (!s.qual[i] && s.tick) begin
                    if (s.qual_cnt[i] == QUAL_LAST) begin
                        n.qual[i] = 1'b1;
                        n.qual_cnt[i] = '0;
                    end else begin
                        n.qual_cnt[i] = s.qual_cnt[i] + 1'b1;
                    end
                end
            end
            // between the limits both the state and the interval are frozen
        end

        // ************************************************************
        // status codes and availability
        // ************************************************************
        for (int i = 0; i < rpqr_pkg::NUM_MEAS_INPUTS; i++) begin
            if (i < rpqr_pkg::NUM_SEL_REFS) begin
                prio_eff = eff_prio(n.prio[i / 2][(i % 2) * rpqr_pkg::PRIO_W +: rpqr_pkg::PRIO_W]);
            end else begin
                prio_eff = rpqr_pkg::PRIO_TOP;
            end
            if (!ref_present_i[i]) begin
                n.status[i] = rpqr_pkg::STAT_ABSENT;
            end else if (!n.qual[i]) begin
                n.status[i] = rpqr_pkg::STAT_DISQUALIFIED;
            end else if (prio_eff == rpqr_pkg::PRIO_NONE) begin
                n.status[i] = rpqr_pkg::STAT_IGNORED;
            end else begin
                n.status[i] = rpqr_pkg::STAT_QUALIFIED;
            end
            if (i < rpqr_pkg::NUM_SEL_REFS) begin
                n.avail[i] = n.qual[i] && prio_eff != rpqr_pkg::PRIO_NONE;
            end
        end

        // walk downward so that an equal priority lets the lower number win
        for (int i = rpqr_pkg::NUM_SEL_REFS - 1; i >= 0; i--) begin
            prio_eff = eff_prio(n.prio[i / 2][(i % 2) * rpqr_pkg::PRIO_W +: rpqr_pkg::PRIO_W]);
            if (n.avail[i] && prio_eff >= best_prio) begin
                best_prio = prio_eff;
                best_ref = 3'(i + 1);
            end
        end
        if (auto_revertive_i) begin
            n.sel_ref = best_ref;
        end

        // ************************************************************
        // loop status and holdover history flag
        // ************************************************************
        n.loop_state = loop_state_i;
        n.active = active_ref_i;
        // a move into holdover (code 000) is not a change of reference
        ref_change = active_ref_i != s.active && active_ref_i != rpqr_pkg::ACTIVE_REF_NONE;
        if (ref_change || free_run_i) begin
            n.hist = 1'b0;
        end else if (history_valid_i) begin
            n.hist = 1'b1;
        end else if (holdover_history_clear_i) begin
            n.hist = 1'b0;
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s <= reset_state();
        end else begin
            s <= n;
        end
    end

    assign spi_out_o = s.spi_out;
    assign spi_out_oe_o = s.spi_oe;
    assign sel_ref_o = s.sel_ref;
    assign ref_avail_o = s.avail;
    assign ref_qualified_o = s.qual;
    assign holdover_history_available_o = s.hist;

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!arst_n_i);

    logic seen_meas0;
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            seen_meas0 <= 1'b0;
        end else if (meas_valid_i && meas_idx_i == 3'h0) begin
            seen_meas0 <= 1'b1;
        end
    end

    AST_OFFSET_ONES_UNTIL_MEASURED: assert property (
        !seen_meas0 |-> s.offset[0] == 8'hFF)
        else $error("offset left all ones before any measurement");
    AST_OFFSET_SAT_POS: assert property (
        meas_valid_i && meas_idx_i == 3'h2 && meas_offset_i > 16'sh007F |=> s.offset[2] == 8'h7F)
        else $error("positive offset did not saturate");
    AST_OFFSET_SAT_NEG: assert property (
        meas_valid_i && meas_idx_i == 3'h3 && meas_offset_i < -16'sh0080 |=> s.offset[3] == 8'h80)
        else $error("negative offset did not saturate");
    AST_ABSENT_STATUS: assert property (
        !ref_present_i[0] |=> s.status[0] == 2'h0 && !s.qual[0])
        else $error("absent reference not reported as absent");
    AST_REJECT_DROPS: assert property (
        ref_present_i[1] && s.magnitude[1] > s.reject && !(meas_valid_i && meas_idx_i == 3'h1) |=> !s.qual[1])
        else $error("reference beyond reject limit stayed qualified");
    AST_QUAL_AFTER_INTERVAL: assert property (
        $rose(s.qual[0]) |-> $past(s.qual_cnt[0]) == QUAL_LAST && $past(s.tick))
        else $error("reference qualified before its interval ran out");
    AST_ZERO_PRIO_IGNORED: assert property (
        s.qual[0] && s.prio[0][3:0] == 4'h0 && $past(ref_present_i[0]) |-> s.status[0] == 2'h2)
        else $error("priority zero reference not reported as ignored");
    AST_HIST_FREERUN_CLEAR: assert property (
        free_run_i |=> !s.hist)
        else $error("history flag survived free run");
    AST_HIST_SET: assert property (
        history_valid_i && !free_run_i && (active_ref_i == s.active || active_ref_i == 3'h0) |=> s.hist)
        else $error("history flag not set");
    AST_SEL_IS_AVAIL: assert property (
        auto_revertive_i |=> s.sel_ref == 3'h0 || s.avail[s.sel_ref - 3'h1])
        else $error("selected reference is not available");

endmodule

//--- rpqr_host.sv
// serial host model for the register port of the bank
// assumes: core_clk_i is the bank clock; serial clock runs at 13 core cycles
`timescale 1ns/1ps

module rpqr_host (
    // clock
    input wire logic core_clk_i,
    // serial pins
    output logic spi_clk_o,
    output logic spi_in_o,
    output logic spi_sel_n_o,
    input wire logic spi_out_i
);
    initial begin
        spi_clk_o = 1'b0;
        spi_in_o = 1'b0;
        spi_sel_n_o = 1'b1;
    end

    // always two bytes, msb first; read data sampled on rises 9..16
    task automatic xfer(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        logic [15:0] f;
        f = {a, d};
        q = 8'h00;
        @(posedge core_clk_i) spi_sel_n_o <= 1'b0;
        for (int i = 15; i >= 0; i--) begin
            @(posedge core_clk_i) spi_in_o <= f[i];
            repeat (6) @(posedge core_clk_i);
            spi_clk_o <= 1'b1;
            if (i < 8) q = {q[6:0], spi_out_i};
            repeat (6) @(posedge core_clk_i);
            spi_clk_o <= 1'b0;
        end
        repeat (6) @(posedge core_clk_i);
        spi_sel_n_o <= 1'b1;
        // released line must not look like the last bit
        spi_in_o <= ~f[0];
        repeat (6) @(posedge core_clk_i);
    endtask
endmodule

//--- rpqr_regs_tb.sv
// self-checking bench of the register bank
// assumes: short tick and interval so qualification takes tens of cycles
`timescale 1ns/1ps

module rpqr_regs_tb;
    logic clk = 1'b0, rst_n = 1'b0, mv = 1'b0, hist = 1'b0, fr = 1'b0, holdover_history_clear = 1'b0, rev = 1'b1;
    logic [2:0] mi = 3'h0, act = 3'h0, sel;
    logic signed [15:0] mo = 16'sh0000;
    logic [6:0] pres = 7'h00, qual;
    logic [3:0] ls = 4'h9;
    logic [5:0] avail;
    logic [7:0] q, p0;
    logic sclk, sdi, ssel_n, sdo, soe, ha;
    logic [31:0] seed = 32'h04F209E5, r;
    logic signed [15:0] offs [7] = '{16'sd6, -16'sd6, 16'sd200, -16'sd300, 16'sd30, 16'sd60, -16'sd4};
    logic [7:0] pc [3] = '{8'hF6, 8'hF5, 8'hF0};
    int fails = 0, compares = 0, cyc = 0, oe_cyc = 0;
    always #5 clk = ~clk;
    rpqr_host host (.core_clk_i(clk), .spi_clk_o(sclk), .spi_in_o(sdi), .spi_sel_n_o(ssel_n), .spi_out_i(sdo));
    rpqr_regs #(.TICK_CYCLES(4), .QUAL_TICKS(3)) DUT (.core_clk_i(clk), .arst_n_i(rst_n), .spi_clk_i(sclk),
        .spi_in_i(sdi), .spi_sel_n_i(ssel_n), .spi_out_o(sdo), .spi_out_oe_o(soe), .meas_valid_i(mv),
        .meas_idx_i(mi), .meas_offset_i(mo), .ref_present_i(pres), .loop_state_i(ls), .active_ref_i(act),
        .history_valid_i(hist), .free_run_i(fr), .holdover_history_clear_i(holdover_history_clear), .auto_revertive_i(rev),
        .sel_ref_o(sel), .ref_avail_o(avail), .ref_qualified_o(qual), .holdover_history_available_o(ha));
    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [3:0] eff(input logic [3:0] p);
        return (p > 4'h6) ? 4'h6 : p;
    endfunction
    function automatic logic [7:0] sat(input logic signed [15:0] o);
        return (o > 127) ? 8'h7F : (o < -128) ? 8'h80 : o[7:0];
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] exp);
        int c0;
        c0 = oe_cyc;
        host.xfer({1'b1, a}, 8'h00, q);
        check(q, exp);
        // pin driven through the data byte only, released afterwards
        check({7'h0, soe}, 8'h00);
        check({7'h0, oe_cyc - c0 > 80 && oe_cyc - c0 < 120}, 8'h01);
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        int c0;
        c0 = oe_cyc;
        host.xfer({1'b0, a}, d, q);
        check({7'h0, oe_cyc != c0}, 8'h00);
    endtask
    // refs 1 and 2 and the follower qualified, refs 3 to 6 not
    task automatic prio_case(input logic [7:0] p);
        logic [3:0] e1, e2;
        e1 = eff(p[3:0]);
        e2 = eff(p[7:4]);
        wr(7'h00, p);
        step(4);
        check({5'h0, sel}, (e1 == 4'h0 || e2 > e1) ? 8'h02 : 8'h01);
        check({2'h0, avail}, {6'h0, e2 != 4'h0, e1 != 4'h0});
    endtask
    task automatic tally_and_finish();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (soe === 1'b1) oe_cyc++;
        if (cyc == 60000) begin
            fails++;
            tally_and_finish();
        end
    end
    initial begin
        step(2);
        rst_n <= 1'b1;
        step(4);
        rd(7'h00, 8'h56);
        rd(7'h02, 8'h12);
        for (int a = 4; a < 11; a++) rd(7'(a), 8'hFF);
        rd(7'h0C, 8'h00);
        rd(7'h0D, 8'h00);
        rd(7'h0E, 8'h09);
        rd(7'h10, 8'h1F);
        rd(7'h11, 8'h19);
        rd(7'h03, 8'h00);
        for (int i = 0; i < 3; i++) begin
            r = rnd();
            if (i == 0) p0 = r[7:0];
            wr(7'(i), r[7:0]);
            rd(7'(i), r[7:0]);
        end
        wr(7'h04, 8'h00);
        rd(7'h04, 8'hFF);
        wr(7'h10, 8'h28); // 20 ppm against 10 ppm, well apart
        wr(7'h11, 8'h14);
        rd(7'h10, 8'h28);
        rd(7'h11, 8'h14);
        pres <= 7'h7F;
        // offsets are fixed, no large steps in mid-run
        for (int i = 0; i < 7; i++) begin
            mv <= 1'b1;
            mi <= 3'(i);
            mo <= offs[i];
            step(1);
        end
        mv <= 1'b0;
        step(60);
        for (int i = 0; i < 7; i++) rd(7'(i + 4), sat(offs[i]));
        check({1'b0, qual}, 8'h43);
        rd(7'h0C, {4'h5, ((p0[7:4] == 4'h0) ? 2'h2 : 2'h3), ((p0[3:0] == 4'h0) ? 2'h2 : 2'h3)});
        rd(7'h0D, 8'h35);
        for (int i = 0; i < 8; i++) prio_case((i < 3) ? pc[i] : (r[7:0] | 8'h11) ^ 8'(rnd()) & 8'hEE);
        prio_case(8'h16);
        // outside revertive operation the selection must hold
        rev <= 1'b0;
        wr(7'h00, 8'h61);
        step(4);
        check({5'h0, sel}, 8'h01);
        rev <= 1'b1;
        pres[0] <= 1'b0;
        step(3);
        rd(7'h0C, 8'h5C);
        pres[0] <= 1'b1;
        step(5);
        check({7'h0, qual[0]}, 8'h00);
        step(40);
        check({7'h0, qual[0]}, 8'h01);
        r = rnd();
        hist <= 1'b1;
        act <= 3'h1;
        ls <= r[3:0];
        rd(7'h0E, {4'h9, r[3:0]});
        hist <= 1'b0;
        act <= 3'h0;
        step(3);
        check({7'h0, ha}, 8'h01);
        holdover_history_clear <= 1'b1;
        step(3);
        check({7'h0, ha}, 8'h00);
        holdover_history_clear <= 1'b0;
        hist <= 1'b1;
        step(3);
        check({7'h0, ha}, 8'h01);
        fr <= 1'b1;
        step(3);
        check({7'h0, ha}, 8'h00);
        tally_and_finish();
    end
endmodule
